// ---- core/auto_cycle_map.svh ----
// Field positions, reset values and timing counts for the cycle scheduler
`ifndef AUTO_CYCLE_MAP_SVH
`define AUTO_CYCLE_MAP_SVH
`define INTERVAL_CODE_W       3
`define INTERVAL_RESET        8'h00
`define CFG_MASK_LSB          4
`define CFG_MASK_MSB          11
`define CLK_HZ                50000000
`define MS_PER_S              1000
`define CYCLES_PER_MS         (`CLK_HZ / `MS_PER_S)
`define INTERVAL_MS_1         1
`define INTERVAL_MS_2         2
`define INTERVAL_MS_3         4
`define INTERVAL_MS_4         8
`define INTERVAL_MS_5         16
`define INTERVAL_MS_6         32
`define INTERVAL_MS_7         64
`define CONV_CYCLES           100
`endif

// ---- core/auto_cycle_pkg.sv ----
// Types for the automatic cycle conversion scheduler
package auto_cycle_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_CONVERT
  } sched_state_e;
  typedef logic [2:0] chan_idx_t;
endpackage

// ---- core/ms_tick_divider.sv ----
// Millisecond enable pulse divider
`timescale 1ns/100ps
`include "auto_cycle_map.svh"
module ms_tick_divider #(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_run,
  output logic      o_ms_tick
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  // Count cycles, pulse once each millisecond while running
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!i_run) begin
      cnt_d = 32'h0;
    end else if (cnt_q == CYCLES_PER_MS - 1) begin
      cnt_d  = 32'h0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_ms_tick = tick_q;
endmodule // ms_tick_divider

// ---- core/auto_cycle_scheduler.sv ----
// Automatic cycle interval conversion scheduler
//
// Overview of operation
// RULE_01: Only low three interval bits pick period.
// RULE_02: Master writes zeros into upper five bits.
// RULE_03: Nonzero code starts one conversion per interval.
// RULE_04: Seven distinct periods, one per code.
// RULE_05: Converter powered down between conversions.
// RULE_06: Zero code stops periodic conversions.
// RULE_07: Only mask-enabled channels are converted.
// RULE_08: Start lowest enabled, advance upward each interval.
// RULE_09: Wrap to lowest enabled channel, repeat.
// RULE_10: Period per code is a parameter table.
`timescale 1ns/100ps
`include "auto_cycle_map.svh"
module auto_cycle_scheduler
  import auto_cycle_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter int unsigned CONV_CYCLES   = `CONV_CYCLES,
  parameter int unsigned MS_CODE1      = `INTERVAL_MS_1,
  parameter int unsigned MS_CODE2      = `INTERVAL_MS_2,
  parameter int unsigned MS_CODE3      = `INTERVAL_MS_3,
  parameter int unsigned MS_CODE4      = `INTERVAL_MS_4,
  parameter int unsigned MS_CODE5      = `INTERVAL_MS_5,
  parameter int unsigned MS_CODE6      = `INTERVAL_MS_6,
  parameter int unsigned MS_CODE7      = `INTERVAL_MS_7
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_interval_wr,
  input  wire logic [7:0]  i_interval_wdata,
  input  wire logic [15:0] i_config,
  input  wire logic        i_conv_done,
  output logic [7:0]       o_interval_rdata,
  output logic             o_power_up,
  output logic             o_conv_start,
  output logic [2:0]       o_conv_channel,
  output logic             o_cycle_active
);

  ////////////////////////////////////////////////////////////////////////
  // Interval code table lookup; code zero has no period
  // Table entries above 16 bits are cut on purpose
  function automatic logic [15:0] code_to_ms(input logic [2:0] code);
    case (code)
      3'h1:    code_to_ms = 16'(MS_CODE1); // RULE_10
      3'h2:    code_to_ms = 16'(MS_CODE2); // RULE_04
      3'h3:    code_to_ms = 16'(MS_CODE3);
      3'h4:    code_to_ms = 16'(MS_CODE4);
      3'h5:    code_to_ms = 16'(MS_CODE5);
      3'h6:    code_to_ms = 16'(MS_CODE6);
      3'h7:    code_to_ms = 16'(MS_CODE7);
      default: code_to_ms = 16'h0;
    endcase
  endfunction

  // Next enabled channel strictly above cur, wrapping to lowest
  // With first set the scan starts at channel zero itself
  // Caller guarantees a nonzero mask, else cur is kept
  function automatic chan_idx_t next_chan(input logic [7:0] mask,
                                          input chan_idx_t  cur,
                                          input logic       first);
    chan_idx_t  res;
    logic       found;
    logic [3:0] idx;
    res   = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = first ? 4'(i - 1) : 4'(cur) + 4'(i);
      if (!found && mask[idx[2:0]]) begin
        res   = idx[2:0];
        found = 1'b1;
      end
    end
    next_chan = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Interval register
  logic [7:0] interval_q;
  logic [7:0] interval_d;
  logic [2:0] code;

  // Strobe loads all eight bits; upper five are only read back
  always_comb begin
    interval_d = interval_q;
    if (i_interval_wr) begin
      interval_d = i_interval_wdata; // Upper bits stored but unused
    end
  end

  // Interval byte; reset clears it so the mode starts off
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      interval_q <= `INTERVAL_RESET;
    end else begin
      interval_q <= interval_d;
    end
  end

  // Only the code field steers timing and mode
  assign code             = interval_q[`INTERVAL_CODE_W-1:0]; // RULE_01
  assign o_interval_rdata = interval_q;

  // Channel mask read live; a change applies at the next pick
  logic [7:0] mask;
  assign mask = i_config[`CFG_MASK_MSB:`CFG_MASK_LSB]; // RULE_07

  ////////////////////////////////////////////////////////////////////////
  // Millisecond enable
  // Enable from the divider and its run request
  logic ms_tick;
  logic running;

  // One-cycle pulse each millisecond, only while waiting
  // A restart from idle always begins a full millisecond
  ms_tick_divider #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_div (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_run      (running),
    .o_ms_tick  (ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Scheduler state
  // State, interval count, conversion timer, channel pointer
  sched_state_e state_q;
  sched_state_e state_d;
  logic [15:0]  ms_q;
  logic [15:0]  ms_d;
  logic [31:0]  conv_q;
  logic [31:0]  conv_d;
  chan_idx_t    chan_q;
  chan_idx_t    chan_d;
  logic         first_q;
  logic         first_d;
  logic         start_q;
  logic         start_d;

  // Divider held cleared outside the wait state
  assign running = (state_q == ST_WAIT);

  // Wait an interval, then convert one enabled channel
  // The divider is held cleared during a conversion, so each period
  // also holds the conversion time
  always_comb begin
    state_d = state_q;
    ms_d    = ms_q;
    conv_d  = conv_q;
    chan_d  = chan_q;
    first_d = first_q;
    start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // Restart the scan at the lowest enabled channel
        first_d = 1'b1;
        ms_d    = 16'h0;
        if (code != 3'h0) begin
          state_d = ST_WAIT; // RULE_03
        end
      end
      ST_WAIT: begin
        // Cleared code drops straight back to idle
        if (code == 3'h0) begin
          state_d = ST_IDLE; // RULE_06
        end else if (ms_tick) begin
          if (ms_q + 16'h1 >= code_to_ms(code)) begin // RULE_03
            ms_d = 16'h0;
            // Empty mask: interval counted, nothing converted
            if (mask != 8'h0) begin
              chan_d  = next_chan(mask, chan_q, first_q); // RULE_08 RULE_09
              first_d = 1'b0;
              start_d = 1'b1;
              conv_d  = 32'h0;
              state_d = ST_CONVERT;
            end
          end else begin
            ms_d = ms_q + 16'h1;
          end
        end
      end
      ST_CONVERT: begin
        // Early done from the converter or the timeout ends it
        conv_d = conv_q + 32'h1;
        if (i_conv_done || conv_q >= CONV_CYCLES - 1) begin
          state_d = (code == 3'h0) ? ST_IDLE : ST_WAIT; // RULE_05 RULE_06
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Register scheduler state
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      ms_q    <= 16'h0;
      conv_q  <= 32'h0;
      chan_q  <= 3'h0;
      first_q <= 1'b1;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ms_q    <= ms_d;
      conv_q  <= conv_d;
      chan_q  <= chan_d;
      first_q <= first_d;
      start_q <= start_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; power request is a decode of the state register
  assign o_power_up     = (state_q == ST_CONVERT); // RULE_05
  assign o_conv_start   = start_q;
  assign o_conv_channel = chan_q;
  assign o_cycle_active = (state_q != ST_IDLE);

endmodule // auto_cycle_scheduler

// ---- dv/auto_cycle_checker_assertions.sv ----
// Port timing checks for the cycle scheduler
`timescale 1ns/100ps
module auto_cycle_checker (
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_interval_wr,
  input wire logic [7:0]  i_interval_wdata,
  input wire logic [15:0] i_config,
  input wire logic        i_conv_done,
  input wire logic [7:0]  o_interval_rdata,
  input wire logic        o_power_up,
  input wire logic        o_conv_start,
  input wire logic [2:0]  o_conv_channel,
  input wire logic        o_cycle_active
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Register, start, power and channel relations
  chk_wr_readback: assert property (i_interval_wr |=>
    o_interval_rdata == $past(i_interval_wdata)) else $error("readback wrong");
  chk_code_activates: assert property (i_interval_wr && i_interval_wdata[2:0] != 3'h0
    |-> ##[1:3] o_cycle_active) else $error("no activation");
  chk_start_powers: assert property (o_conv_start |->
    o_power_up && !$past(o_power_up)) else $error("start without power rise");
  chk_start_gap: assert property (o_conv_start |=>
    !o_conv_start [*8]) else $error("starts too close");
  chk_power_bound: assert property (o_conv_start |->
    ##[1:5] !o_power_up) else $error("power stays up");
  chk_power_down: assert property ($fell(o_power_up) |->
    !o_power_up [*8]) else $error("power back too soon");
  chk_zero_stops: assert property (i_interval_wr && i_interval_wdata[2:0] == 3'h0
    |-> ##[1:7] !o_cycle_active) else $error("mode not ended");
  chk_idle_quiet: assert property (!o_cycle_active |->
    !o_conv_start) else $error("start while idle");
  chk_mask_only: assert property (o_conv_start |->
    (($past(i_config) >> (4 + o_conv_channel)) & 16'h0001) == 16'h0001)
    else $error("channel not enabled");
endmodule // auto_cycle_checker
bind auto_cycle_scheduler auto_cycle_checker chk_u (.i_core_clk, .i_sys_rst, .i_interval_wr,
  .i_interval_wdata, .i_config, .i_conv_done, .o_interval_rdata, .o_power_up,
  .o_conv_start, .o_conv_channel, .o_cycle_active);

// ---- dv/interval_master.sv ----
// Bus master model writing the interval register
`timescale 1ns/100ps
module interval_master (
  input  wire logic       i_core_clk,
  input  wire logic       i_go,
  input  wire logic [2:0] i_code,
  output logic            o_wr = 1'b0,
  output logic [7:0]      o_wdata = 8'h00
);
  // One-cycle strobe; data toggles when not writing
  always_ff @(posedge i_core_clk) begin
    o_wr    <= i_go;
    o_wdata <= i_go ? {5'h00, i_code} : ~o_wdata;
  end
endmodule // interval_master

// ---- dv/auto_cycle_scheduler_bench.sv ----
// Self-checking bench for the cycle scheduler
`timescale 1ns/100ps
module auto_cycle_scheduler_bench;
  localparam int CPM = 10;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, go = 1'b0, i_conv_done = 1'b0, i_interval_wr;
  logic o_power_up, o_conv_start, o_cycle_active;
  logic [2:0] code = 3'h0, o_conv_channel, ch;
  logic [7:0] i_interval_wdata, o_interval_rdata, mask;
  logic [15:0] i_config = 16'h0000;
  logic [31:0] seed = 32'h1477, dn = 32'h1477;
  int miscompares = 0, checks_done = 0, n;
  auto_cycle_scheduler #(.CYCLES_PER_MS(CPM), .CONV_CYCLES(4)) dut_u (.i_core_clk, .i_sys_rst,
    .i_interval_wr, .i_interval_wdata, .i_config, .i_conv_done, .o_interval_rdata,
    .o_power_up, .o_conv_start, .o_conv_channel, .o_cycle_active);
  interval_master host_u (.i_core_clk, .i_go(go), .i_code(code), .o_wr(i_interval_wr),
    .o_wdata(i_interval_wdata));
  //////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Next enabled channel above c, or lowest when first
  function automatic logic [2:0] next_ch(input logic [7:0] m, input logic [2:0] c, input logic f);
    logic [2:0] s;
    s = f ? 3'h0 : 3'(c + 3'h1);
    for (int k = 0; k < 8; k++) if (m[3'(s + k)]) return 3'(s + k);
    return c;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD t=%0t seen %0h want %0h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_start;
    n = 0;
    do begin @(posedge i_core_clk); #1; n++; end while (!o_conv_start && n < 2000);
    check(o_conv_start, 1'b1);
  endtask
  task automatic put(input logic [2:0] c);
    @(posedge i_core_clk);
    code <= c;
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
  endtask
  // Clock, random early conversion end, watchdog
  initial forever #10 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    dn = xs(dn);
    i_conv_done <= o_power_up & dn[0];
  end
  initial begin
    repeat (40000) @(posedge i_core_clk);
    miscompares++;
    test_done();
  end
  // Every interval code with a random channel mask
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    #1;
    check({o_interval_rdata, o_cycle_active, o_power_up, o_conv_start}, 11'h000);
    for (int c = 1; c < 8; c++) begin
      @(posedge i_core_clk);
      seed = xs(seed);
      mask = seed[7:0] | (8'h01 << seed[10:8]);
      i_config <= {seed[31:28], mask, seed[27:24]};
      put(3'(c));
      wait_start();
      ch = next_ch(mask, 3'h0, 1'b1);
      check(o_conv_channel, ch);
      repeat (4) begin
        wait_start();
        ch = next_ch(mask, ch, 1'b0);
        check(o_conv_channel, ch);
        check(n >= (CPM << (c - 1)) && n <= (CPM << (c - 1)) + 8, 1'b1);
      end
      check(o_interval_rdata, {5'h00, 3'(c)});
      put(3'h0);
      repeat (8) @(posedge i_core_clk);
      #1;
      check({o_cycle_active, o_power_up}, 2'b00);
    end
    // Reset in mid-conversion, then the scan restarts at the lowest channel
    @(posedge i_core_clk);
    mask = 8'ha5;
    i_config <= {4'h0, mask, 4'h0};
    put(3'h1);
    wait_start();
    check(o_conv_channel, 3'h0);
    @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    #1;
    check({o_interval_rdata, o_cycle_active, o_power_up, o_conv_start}, 11'h000);
    put(3'h1);
    wait_start();
    check(o_conv_channel, next_ch(mask, 3'h0, 1'b1));
    test_done();
  end
endmodule // auto_cycle_scheduler_bench
